//--- logic/tpo_pkg.sv
// Package for the four-channel timer: register map, field positions, reset values.
// Assumes an 8-bit register port with a 5-bit word address.
package tpo_pkg;

  localparam int DW = 8;
  localparam int AW = 5;
  localparam int NCH = 4;

  // Register word addresses
  localparam logic [4:0] A_STAT = 5'h00;
  localparam logic [4:0] A_CNT_H = 5'h01;
  localparam logic [4:0] A_CNT_L = 5'h02;
  localparam logic [4:0] A_PER_H = 5'h03;
  localparam logic [4:0] A_PER_L = 5'h04;
  localparam int A_CH_BASE = 5;
  localparam int A_CH_STRIDE = 3;

  // Timer status/control fields
  localparam int ST_FLAG = 7;
  localparam int ST_IEN = 6;
  localparam int ST_HALT = 5;
  localparam int ST_CLR = 4;
  localparam int PS_LSB = 0;
  localparam int PS_W = 3;

  // Channel control/status fields
  localparam int CC_FLAG = 7;
  localparam int CC_IEN = 6;
  localparam int CC_BUF = 5;
  localparam int CC_MODE = 4;
  localparam int CC_ELS_LSB = 2;
  localparam int CC_TOV = 1;
  localparam int CC_MAX = 0;

  // Reset values and codes
  localparam logic HALT_RST = 1'b1;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [2:0] PS_EXT = 3'h7;
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_RISE = 2'h1;
  localparam logic [1:0] ELS_FALL = 2'h2;
  localparam int SYNC_W = 5;

  typedef enum logic [1:0] {TPO_CAPTURE, TPO_COMPARE, TPO_BUFFERED} tpo_mode_t;

  // Mode select pair: buffer bit outranks the low bit
  function automatic tpo_mode_t tpo_decode(input logic buf_sel, input logic low_sel);
    if (buf_sel) return TPO_BUFFERED;
    if (low_sel) return TPO_COMPARE;
    return TPO_CAPTURE;
  endfunction

  // Word address of channel c, register k (0 control, 1 high, 2 low)
  function automatic logic [4:0] tpo_ch_addr(input int c, input int k);
    return 5'(A_CH_BASE + c * A_CH_STRIDE + k);
  endfunction

endpackage

//--- logic/tpo_pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the pins change no faster than half the system clock.
module tpo_pin_sync
  import tpo_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire logic [SYNC_W-1:0] pin_in, // Raw pin levels
  output logic [SYNC_W-1:0] pin_filt // Settled levels
);

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] filt;
  } tpo_sync_t;

  tpo_sync_t sy_reg;
  tpo_sync_t sy_next;

  // A level counts only once stages two and three agree
  always_comb begin
    sy_next = sy_reg;
    sy_next.s1 = pin_in;
    sy_next.s2 = sy_reg.s1;
    sy_next.s3 = sy_reg.s2;
    for (int i = 0; i < SYNC_W; i++) begin
      if (sy_reg.s2[i] == sy_reg.s3[i]) sy_next.filt[i] = sy_reg.s3[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sy_reg <= '0;
    end else begin
      sy_reg <= sy_next;
    end
  end

  assign pin_filt = sy_reg.filt;

endmodule

//--- logic/tpo_timer.sv
// Four-channel timer with counter, prescaler, compare/capture and PWM channels.
// Assumes a register master on sys_clk and asynchronous pins through tpo_pin_sync.
//
// Behaviour
// - Mode bits 0:1 mean unbuffered compare, 1:0 mean buffered pair.
// - Compare drives pin low for select 1:0, high for 1:1.
// - Toggle-at-wrap set makes the output toggle at every counter wrap.
// - Channel 0 buffer bit links channels 0 and 1, starts on channel 0.
// - Channel 2 buffer bit links channels 2 and 3, starts on channel 2.
// - Toggle-at-wrap clear gives no wrap toggle; with clear on compare, 0% duty.
// - Full-duty bit with toggle-at-wrap clear holds output high.
// - Wrap flag sets when counter rolls to zero after the period limit.
// - Channel flag sets on each capture or compare; enable gates its request.
// - In wait state the timer runs, ignores the port, requests still wake.
// - Counter stops while a debug break is active.
// - During break, flag clears only happen with break-clear enabled.
// - First clear step before break survives it; second step later clears.
// - Prescale select all ones takes the external clock pin as count clock.
// - Selected external clock pin is an input whatever its direction bit.
// - Each channel pin is capture input or compare output independently, except the odd pin of a linked pair, which goes to the port.
// - Wrap flag clears by read then write zero; new wrap cancels it.
// - Halt bit freezes counting; reset sets it.
// - Counter clear bit zeroes counter and prescaler and reads as zero.
// - Prescale codes 0 to 6 divide by 1 to 64; reset clears them.
// - Last written register of a linked pair governs from next wrap.
module tpo_timer
  import tpo_pkg::*;
(
  input wire logic sys_clk, // System clock, 25 MHz
  input wire logic rst, // Synchronous reset, high
  input wire logic [AW-1:0] reg_addr, // Register word address
  input wire logic [DW-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [DW-1:0] reg_rdata, // Read data, cycle after strobe
  input wire logic cpu_wait, // Processor in wait state
  input wire logic break_active, // Debug break in progress
  input wire logic break_clear_en, // Break-time flag clears allowed
  input wire logic port_d6_direction, // Port direction bit of clock pin
  input wire logic ext_timer_clock_pin_in, // External clock pin level
  output logic ext_timer_clock_pin_oe, // Port drive enable of clock pin
  input wire logic [NCH-1:0] chan_pin_in, // Channel pin levels
  output logic [NCH-1:0] chan_pin_out, // Channel pin drive level
  output logic [NCH-1:0] chan_pin_oe, // Channel pin drive enable
  output logic wrap_irq, // Wrap interrupt request
  output logic [NCH-1:0] chan_irq, // Channel interrupt requests
  output logic timer_wake // Any request, wakes the processor
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [6:0] pre;
    logic halt;
    logic wrap_ien;
    logic [2:0] ps;
    logic wrap_flag;
    logic wrap_arm;
    logic [15:0] period;
    logic [NCH-1:0][15:0] chv;
    logic [NCH-1:0][6:0] cctl;
    logic [NCH-1:0] cflag;
    logic [NCH-1:0] carm;
    logic [1:0] lastw;
    logic [1:0] act;
    logic [NCH-1:0] pin_prev;
    logic ext_prev;
    logic [NCH-1:0] pout;
    logic [NCH-1:0] poe;
    logic ext_oe;
    logic [DW-1:0] rdata;
    logic wrap_irq;
    logic [NCH-1:0] chan_irq;
    logic wake;
  } tpo_state_t;

  tpo_state_t st_reg;
  tpo_state_t st_next;
  logic [SYNC_W-1:0] pin_filt;
  logic [NCH-1:0] chan_f;
  logic ext_f;
  logic bus_wr;
  logic bus_rd;
  logic flag_lock;
  logic ext_sel;
  logic run;
  logic [6:0] pmask;
  logic tick;
  logic wrap;
  logic [15:0] cnt_step;

  // Pins arrive from outside the clock domain
  tpo_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in({ext_timer_clock_pin_in, chan_pin_in}),
    .pin_filt(pin_filt)
  );

  assign chan_f = pin_filt[NCH-1:0];
  assign ext_f = pin_filt[NCH];

  // Port is shut while the processor waits; the timer itself keeps going
  assign bus_wr = reg_wr & ~cpu_wait;
  assign bus_rd = reg_rd & ~cpu_wait;
  assign flag_lock = break_active & ~break_clear_en;
  assign ext_sel = (st_reg.ps == PS_EXT);
  assign run = ~st_reg.halt & ~break_active;

  // Divide-by-2^ps enable; ps of zero gives a tick every cycle
  assign pmask = 7'((8'h01 << st_reg.ps) - 8'h01);
  assign tick = run & (ext_sel ? (ext_f & ~st_reg.ext_prev)
                               : ((st_reg.pre & pmask) == pmask));
  assign wrap = tick & (st_reg.cnt == st_reg.period);
  // Value the counter takes at this tick
  assign cnt_step = wrap ? 16'h0000 : st_reg.cnt + 16'h0001;

  // Next-state logic for the whole timer
  always_comb begin
    tpo_mode_t md;
    logic [6:0] cc;
    logic [1:0] els;
    logic [15:0] cv;
    logic odd_off;
    logic out_mode;
    logic cap_mode;
    logic ev;
    logic rise;
    logic fall;
    md = TPO_CAPTURE;
    cc = '0;
    els = '0;
    cv = '0;
    odd_off = 1'b0;
    out_mode = 1'b0;
    cap_mode = 1'b0;
    ev = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    st_next = st_reg;
    st_next.rdata = '0;
    st_next.ext_prev = ext_f;

    // Counter and prescaler; the prescaler rests while an external clock drives
    if (run && !ext_sel) st_next.pre = st_reg.pre + 7'h01;
    if (tick) st_next.cnt = cnt_step;

    // Buffered pairs swap to the last written register at each wrap
    for (int p = 0; p < 2; p++) begin
      if (wrap && st_reg.cctl[2 * p][CC_BUF]) st_next.act[p] = st_reg.lastw[p];
    end

    // Status register: read arms the clear, write zero finishes it
    if (bus_rd && reg_addr == A_STAT) begin
      st_next.rdata = {st_reg.wrap_flag, st_reg.wrap_ien, st_reg.halt, 2'b00, st_reg.ps};
      if (st_reg.wrap_flag && !flag_lock) st_next.wrap_arm = 1'b1;
    end
    if (bus_wr && reg_addr == A_STAT) begin
      st_next.wrap_ien = reg_wdata[ST_IEN];
      st_next.halt = reg_wdata[ST_HALT];
      st_next.ps = reg_wdata[PS_LSB +: PS_W];
      if (!reg_wdata[ST_FLAG] && st_reg.wrap_arm && !flag_lock) begin
        st_next.wrap_flag = 1'b0;
        st_next.wrap_arm = 1'b0;
      end
      // Clear bit is not stored, so it always reads back as zero
      if (reg_wdata[ST_CLR]) begin
        st_next.cnt = 16'h0000;
        st_next.pre = 7'h00;
      end
    end
    // A wrap in the same cycle beats the clear and drops the armed step
    if (wrap) begin
      st_next.wrap_flag = 1'b1;
      st_next.wrap_arm = 1'b0;
    end

    // Counter and period registers
    if (bus_rd) begin
      case (reg_addr)
        A_CNT_H: st_next.rdata = st_reg.cnt[15:8];
        A_CNT_L: st_next.rdata = st_reg.cnt[7:0];
        A_PER_H: st_next.rdata = st_reg.period[15:8];
        A_PER_L: st_next.rdata = st_reg.period[7:0];
        default: ;
      endcase
    end
    if (bus_wr && reg_addr == A_PER_H) st_next.period[15:8] = reg_wdata;
    if (bus_wr && reg_addr == A_PER_L) st_next.period[7:0] = reg_wdata;

    // Channels
    for (int c = 0; c < NCH; c++) begin
      cc = st_reg.cctl[c];
      md = tpo_decode(cc[CC_BUF], cc[CC_MODE]);
      els = cc[CC_ELS_LSB +: 2];
      // The odd channel of a linked pair is handed back to the port
      odd_off = (c % 2 == 1) && st_reg.cctl[c & 2][CC_BUF];
      cv = (md == TPO_BUFFERED && st_reg.act[c / 2]) ? st_reg.chv[c | 1]
                                                     : st_reg.chv[c];
      out_mode = !odd_off && md != TPO_CAPTURE && els != ELS_OFF;
      cap_mode = !odd_off && md == TPO_CAPTURE && els != ELS_OFF;
      st_next.poe[c] = out_mode;
      rise = chan_f[c] & ~st_reg.pin_prev[c];
      fall = ~chan_f[c] & st_reg.pin_prev[c];
      st_next.pin_prev[c] = chan_f[c];
      ev = 1'b0;
      if (out_mode) begin
        // Wrap toggle first, so a compare in the same tick sets the final level
        if (wrap && cc[CC_TOV]) st_next.pout[c] = ~st_reg.pout[c];
        // Compare fires as the counter steps onto the value, so width equals it
        if (tick && cnt_step == cv) begin
          ev = 1'b1;
          case (els)
            ELS_TOGGLE: st_next.pout[c] = ~st_next.pout[c];
            ELS_CLEAR: st_next.pout[c] = 1'b0;
            default: st_next.pout[c] = 1'b1;
          endcase
        end
        if (cc[CC_MAX] && !cc[CC_TOV]) st_next.pout[c] = 1'b1;
      end else if (cap_mode) begin
        case (els)
          ELS_RISE: ev = rise;
          ELS_FALL: ev = fall;
          default: ev = rise | fall;
        endcase
        if (ev) st_next.chv[c] = st_reg.cnt;
      end

      // Control register access with the two-step flag clear
      if (bus_rd && reg_addr == tpo_ch_addr(c, 0)) begin
        st_next.rdata = {st_reg.cflag[c], cc};
        if (st_reg.cflag[c] && !flag_lock) st_next.carm[c] = 1'b1;
      end
      if (bus_wr && reg_addr == tpo_ch_addr(c, 0)) begin
        st_next.cctl[c] = reg_wdata[6:0];
        // Only the even channels own a buffer bit
        if (c % 2 == 1) st_next.cctl[c][CC_BUF] = 1'b0;
        // Fresh link: the even channel governs first
        if (c % 2 == 0 && reg_wdata[CC_BUF] && !cc[CC_BUF]) begin
          st_next.act[c / 2] = 1'b0;
          st_next.lastw[c / 2] = 1'b0;
        end
        if (!reg_wdata[CC_FLAG] && st_reg.carm[c] && !flag_lock) begin
          st_next.cflag[c] = 1'b0;
          st_next.carm[c] = 1'b0;
        end
      end

      // Channel value registers
      if (bus_rd && reg_addr == tpo_ch_addr(c, 1)) st_next.rdata = st_reg.chv[c][15:8];
      if (bus_rd && reg_addr == tpo_ch_addr(c, 2)) st_next.rdata = st_reg.chv[c][7:0];
      if (bus_wr && reg_addr == tpo_ch_addr(c, 1)) st_next.chv[c][15:8] = reg_wdata;
      if (bus_wr && reg_addr == tpo_ch_addr(c, 2)) st_next.chv[c][7:0] = reg_wdata;
      if (bus_wr && st_reg.cctl[c & 2][CC_BUF]
          && (reg_addr == tpo_ch_addr(c, 1) || reg_addr == tpo_ch_addr(c, 2))) begin
        st_next.lastw[c / 2] = (c % 2 == 1);
      end

      // An event beats a clear landing in the same cycle
      if (ev) begin
        st_next.cflag[c] = 1'b1;
        st_next.carm[c] = 1'b0;
      end
      st_next.chan_irq[c] = st_next.cflag[c] & st_next.cctl[c][CC_IEN];
    end

    // Requests follow the flags they come from, in the same cycle
    st_next.wrap_irq = st_next.wrap_flag & st_next.wrap_ien;
    st_next.wake = st_next.wrap_irq | (|st_next.chan_irq);
    st_next.ext_oe = port_d6_direction & (st_next.ps != PS_EXT);
  end

  // State register; counter halted out of reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.halt <= HALT_RST;
      st_reg.period <= PERIOD_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign chan_pin_out = st_reg.pout;
  assign chan_pin_oe = st_reg.poe;
  assign ext_timer_clock_pin_oe = st_reg.ext_oe;
  assign wrap_irq = st_reg.wrap_irq;
  assign chan_irq = st_reg.chan_irq;
  assign timer_wake = st_reg.wake;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_rd_flag;
    bus_rd && reg_addr == A_STAT && st_reg.wrap_flag && !flag_lock && !wrap;
  endsequence
  sequence s_wr_zero;
    bus_wr && reg_addr == A_STAT && !reg_wdata[ST_FLAG] && !flag_lock && !wrap;
  endsequence

  property p_wrap_set;
    wrap |=> st_reg.wrap_flag && st_reg.cnt == 16'h0000;
  endproperty
  a_wrap_set: assert property (p_wrap_set) else $error("wrap flag not set");

  property p_wrap_clear;
    s_rd_flag ##1 !wrap ##1 s_wr_zero |=> !st_reg.wrap_flag;
  endproperty
  a_wrap_clear: assert property (p_wrap_clear) else $error("wrap clear failed");

  property p_write_one;
    bus_wr && reg_addr == A_STAT && reg_wdata[ST_FLAG] && st_reg.wrap_flag |=> st_reg.wrap_flag;
  endproperty
  a_write_one: assert property (p_write_one) else $error("write one cleared flag");

  property p_break_lock;
    flag_lock && st_reg.wrap_flag |=> st_reg.wrap_flag;
  endproperty
  a_break_lock: assert property (p_break_lock) else $error("flag changed in break");

  property p_break_stop;
    break_active && !bus_wr |=> $stable(st_reg.cnt);
  endproperty
  a_break_stop: assert property (p_break_stop) else $error("counter ran in break");

  property p_halt;
    st_reg.halt && !bus_wr |=> $stable(st_reg.cnt);
  endproperty
  a_halt: assert property (p_halt) else $error("counter ran while halted");

  property p_div2;
    st_reg.ps == 3'h1 && !st_reg.pre[0] && !bus_wr |=> $stable(st_reg.cnt);
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two wrong");

  property p_ext_input;
    st_reg.ps == PS_EXT && !bus_wr |=> !ext_timer_clock_pin_oe;
  endproperty
  a_ext_input: assert property (p_ext_input) else $error("clock pin driven");

  property p_wrap_irq;
    $rose(st_reg.wrap_flag) && st_reg.wrap_ien |-> wrap_irq && timer_wake;
  endproperty
  a_wrap_irq: assert property (p_wrap_irq) else $error("wrap request missing");

endmodule

//--- sim/tpo_cpu_model.sv
// Processor-side model of the timer's register port: one-cycle strobes.
// Assumes one clock and read data standing only in the cycle after a read.
module tpo_cpu_model
  import tpo_pkg::*;
(
  input wire logic sys_clk, // System clock
  output logic [AW-1:0] reg_addr, // Word address
  output logic [DW-1:0] reg_wdata, // Write data
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  input wire logic [DW-1:0] reg_rdata // Read data
);
  // Idle bus at time zero
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Write; the next call waits an edge, so strobes never merge in one step
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read; data are taken just after the edge that samples the strobe
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // 16-bit values go high byte first; the design does not latch them
  task automatic wr16(input logic [AW-1:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 5'h1, v[7:0]);
  endtask
endmodule

//--- sim/timer_pwm_overflow_control_test.sv
// Self-checking bench for the four-channel timer: registers, PWM, flags, break.
// Assumes tpo_timer and the processor model; pins are driven from here.
module timer_pwm_overflow_control_test
  import tpo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst, cpu_wait, break_active, break_clear_en, port_d6_direction, ext_pin;
  logic [NCH-1:0] chan_pin_in, chan_pin_out, chan_pin_oe, chan_irq;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, ext_oe, wrap_irq, timer_wake;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  tpo_cpu_model i_cpu (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  tpo_timer i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_wait(cpu_wait),
    .break_active(break_active), .break_clear_en(break_clear_en),
    .port_d6_direction(port_d6_direction), .ext_timer_clock_pin_in(ext_pin),
    .ext_timer_clock_pin_oe(ext_oe), .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
    .chan_pin_oe(chan_pin_oe), .wrap_irq(wrap_irq), .chan_irq(chan_irq),
    .timer_wake(timer_wake));

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, well above the roughly 1,700 cycles the tests need
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rc(input logic [AW-1:0] a, input logic [DW-1:0] e);
    logic [DW-1:0] d;
    i_cpu.rd(a, d);
    check({8'h0, d}, {8'h0, e});
  endtask

  function automatic logic [AW-1:0] ca(input int c, input int k);
    return 5'(A_CH_BASE + A_CH_STRIDE * c + k);
  endfunction

  // Highs over four periods of four counts for compare width w
  function automatic int exp_highs(input logic [7:0] c, input int w);
    if (!c[CC_TOV]) return c[CC_MAX] ? 16 : 0;
    return c[CC_ELS_LSB] ? 16 - 4 * w : 4 * w;
  endfunction

  // Settle, then count high cycles over 16 clocks
  task automatic highs(input int i, output int h);
    h = 0;
    repeat (8) @(posedge sys_clk);
    repeat (16) begin
      @(posedge sys_clk);
      #1;
      if (chan_pin_out[i] === 1'b1) h++;
    end
  endtask

  // Halt, clear, period 3, width, control, release
  task automatic pwm_setup(input int c, input logic [7:0] ctl, input logic [15:0] w);
    i_cpu.wr(A_STAT, 8'h30);
    i_cpu.wr16(A_PER_H, 16'h0003);
    i_cpu.wr16(ca(c, 1), w);
    i_cpu.wr(ca(c, 0), ctl);
    i_cpu.wr(A_STAT, 8'h00);
  endtask

  initial begin
    int h;
    int n;
    logic [7:0] d;
    logic [15:0] v;
    logic [7:0] ctls [4] = '{8'h5a, 8'h5e, 8'h58, 8'h59};
    rst = 1'b1;
    {cpu_wait, break_active, break_clear_en, port_d6_direction, ext_pin} = '0;
    chan_pin_in = '0;
    void'($urandom(55356));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset state, stays halted, unmapped read
    rc(A_STAT, 8'h20);
    rc(A_PER_H, 8'hff);
    rc(A_CNT_L, 8'h00);
    rc(5'h1f, 8'h00);
    $display("test reset done");
    // Each divider: about eight counts over 8*div cycles
    for (int ps = 0; ps < 7; ps++) begin
      i_cpu.wr(A_STAT, 8'h30 | 8'(ps));
      i_cpu.wr(A_STAT, 8'(ps));
      repeat ((8 << ps) - 3) @(posedge sys_clk);
      i_cpu.wr(A_STAT, 8'h20 | 8'(ps));
      i_cpu.rd(A_CNT_L, d);
      check(16'(d >= 8'd7 && d <= 8'd9), 16'h1);
      rc(A_STAT, 8'h20 | 8'(ps));
    end
    i_cpu.wr(A_STAT, 8'h30);
    rc(A_CNT_L, 8'h00);
    $display("test prescaler done");
    // Wrap flag, request, cancelled and real clears
    i_cpu.wr16(A_PER_H, 16'h0003);
    i_cpu.wr(A_STAT, 8'h40);
    repeat (8) @(posedge sys_clk);
    #1;
    check(16'(wrap_irq), 16'h1);
    rc(A_STAT, 8'hc0);
    repeat (8) @(posedge sys_clk);
    i_cpu.wr(A_STAT, 8'h60);
    rc(A_STAT, 8'he0);
    // Writing one with the clear armed must leave the flag alone
    i_cpu.wr(A_STAT, 8'he0);
    rc(A_STAT, 8'he0);
    i_cpu.wr(A_STAT, 8'h60);
    rc(A_STAT, 8'h60);
    check(16'(wrap_irq), 16'h0);
    i_cpu.wr(A_STAT, 8'he0);
    rc(A_STAT, 8'h60);
    $display("test wrap flag done");
    // Break: counter stops, locked and unlocked clears
    i_cpu.wr(A_STAT, 8'h40);
    repeat (6) @(posedge sys_clk);
    i_cpu.wr(A_STAT, 8'h60);
    rc(A_STAT, 8'he0);
    break_active <= 1'b1;
    i_cpu.wr(A_STAT, 8'h60);
    rc(A_STAT, 8'he0);
    break_active <= 1'b0;
    i_cpu.wr(A_STAT, 8'h60);
    rc(A_STAT, 8'h60);
    i_cpu.wr(A_STAT, 8'h40);
    repeat (6) @(posedge sys_clk);
    break_active <= 1'b1;
    i_cpu.rd(A_CNT_L, d);
    repeat (5) @(posedge sys_clk);
    rc(A_CNT_L, d);
    break_clear_en <= 1'b1;
    rc(A_STAT, 8'hc0);
    i_cpu.wr(A_STAT, 8'h60);
    break_active <= 1'b0;
    break_clear_en <= 1'b0;
    rc(A_STAT, 8'h60);
    $display("test break done");
    // Compare actions, wrap toggle, 0% and 100% duty, channel flag
    foreach (ctls[i]) begin
      pwm_setup(0, ctls[i], 16'h0001);
      highs(0, h);
      check(16'(h), 16'(exp_highs(ctls[i], 1)));
      check(16'(chan_pin_oe[0]), 16'h1);
      rc(ca(0, 0), ctls[i] | 8'h80);
    end
    check(16'(chan_irq[0]), 16'h1);
    i_cpu.wr(ca(1, 0), 8'h04);
    chan_pin_in[1] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rc(ca(1, 0), 8'h84);
    check(16'(chan_pin_oe[1]), 16'h0);
    // Armed channel flag clears on write zero; falling edge capture then sets it
    i_cpu.wr(ca(1, 0), 8'h08);
    rc(ca(1, 0), 8'h08);
    chan_pin_in[1] <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rc(ca(1, 0), 8'h88);
    $display("test compare done");
    // Linked pairs: leader starts, last written set governs from next wrap
    for (int p = 0; p < 4; p += 2) begin
      pwm_setup(p, 8'h2a, 16'h0001);
      highs(p, h);
      check(16'(h), 16'h4);
      check(16'(chan_pin_oe[p + 1]), 16'h0);
      i_cpu.wr16(ca(p + 1, 1), 16'h0002);
      highs(p, h);
      check(16'(h), 16'h8);
      i_cpu.wr16(ca(p, 1), 16'h0003);
      highs(p, h);
      check(16'(h), 16'hc);
    end
    $display("test buffered done");
    // External clock: random pulse count at one eighth of the bus clock
    port_d6_direction <= 1'b1;
    i_cpu.wr16(A_PER_H, 16'hffff);
    i_cpu.wr(A_STAT, 8'h37);
    rc(A_CNT_L, 8'h00);
    check(16'(ext_oe), 16'h0);
    i_cpu.wr(A_STAT, 8'h07);
    n = 5 + $urandom % 10;
    repeat (n) begin
      repeat (4) @(posedge sys_clk);
      ext_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ext_pin <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    i_cpu.wr(A_STAT, 8'h27);
    rc(A_CNT_L, 8'(n));
    i_cpu.wr(A_STAT, 8'h20);
    // Wrap flag is still up from the modulation runs
    rc(A_STAT, 8'ha0);
    check(16'(ext_oe), 16'h1);
    $display("test external clock done");
    // Wait state: accesses refused, timer runs, request wakes
    i_cpu.wr16(A_PER_H, 16'h0003);
    // Clear the counter too, so a wrap comes within four counts
    i_cpu.wr(A_STAT, 8'h50);
    cpu_wait <= 1'b1;
    i_cpu.wr(A_STAT, 8'h20);
    rc(A_STAT, 8'h00);
    check(16'(timer_wake), 16'h1);
    cpu_wait <= 1'b0;
    rc(A_STAT, 8'hc0);
    i_cpu.wr(A_STAT, 8'h60);
    $display("test wait done");
    // Random period values read back
    repeat (4) begin
      v = 16'($urandom);
      i_cpu.wr16(A_PER_H, v);
      rc(A_PER_H, v[15:8]);
      rc(A_PER_L, v[7:0]);
    end
    $display("test period readback done");
    tally_and_finish();
  end
endmodule
